/* File: ipfa_fetch_arbiter.sv */
// Purpose: Instruction fetch unit with its eight port memory arbiter.
// Assumes: Microinstruction fields, memory strobes and port requests are
//          synchronous to sys_clk; every output is registered, so an
//          answer appears one clock after the inputs that cause it.
// Notes:   A fetch source seen while stall is high is ignored.
//          Port 0 belongs to the fetch unit; its request pin is unused.
//          Selects of the lower group stay low while the gate is open,
//          so a lower group grant shows one clock after the gate closes.
//          Priority is fixed; a busy upper port can starve the lower group.
//          An offset load discards the current block and refetches.
//          The BUS value is zero whenever bus_out_en is low.
// Functional notes
// (R1) Frame and offset load from BUS destination
// (R2) Frame or offset driven onto BUS as source
// (R3) Fetch address is frame times four plus offset
// (R4) Address drivers on only during fetch grant
// (R5) Eight holding bytes load from 64-bit read
// (R6) Load when grant-and-strobe enable deasserts
// (R7) Low three address bits select next byte
// (R8) Selected byte on BUS for any fetch source
// (R9) Offset counter increments when byte taken
// (R10) Eighth byte taken requests block, except special
// (R11) Offset load requests block; held in flip-flop
// (R12) Stall when fetch referenced, block not ready; the code raises stall whenever the block is not ready
// (R13) Eight active-low requests, select to chosen port
// (R14) Cycle control closes gate after pending seen
// (R15) Closed gate freezes requests, selects highest
// (R16) Upper group outranks lower; fixed order within
// (R17) Four selects qualified by closed gate
// (R18) Ports withdraw requests on clear request
// (R19) Request clears on granted clear; load readies block
`timescale 1ns/100ps
`default_nettype none

module ipfa_fetch_arbiter (
  input  wire logic                            sys_clk,
  input  wire logic                            arst_n,
  input  wire ipfa_pkg::ipfa_uop_s             uop,
  input  wire logic [ipfa_pkg::WORD_W-1:0]     bus_in,
  input  wire logic [ipfa_pkg::READ_W-1:0]     mem_read_data,
  input  wire logic                            memory_data_strobe,
  input  wire logic                            arbitration_open,
  input  wire logic                            clear_request,
  input  wire logic [ipfa_pkg::PORTS-1:0]      port_request_n,
  output logic      [ipfa_pkg::WORD_W-1:0]     bus_out,
  output logic                                 bus_out_en,
  output logic      [ipfa_pkg::ADDR_W-1:0]     mem_addr,
  output logic                                 mem_addr_en,
  output logic      [ipfa_pkg::PORTS-1:0]      port_select,
  output logic                                 request_pending,
  output logic                                 fetch_request_n,
  output logic                                 stall
);

  ipfa_pkg::ipfa_state_s state_reg;
  ipfa_pkg::ipfa_state_s state_next;

  // Highest pending port of one group of four, one-hot
  // Within a group the higher index wins
  function automatic logic [ipfa_pkg::GROUP-1:0] ipfa_group_pick(
    input logic [ipfa_pkg::GROUP-1:0] reqs
  );
    logic [ipfa_pkg::GROUP-1:0] one_hot;
    logic                       found;
    one_hot = {ipfa_pkg::GROUP{1'b0}};
    found   = 1'b0;
    for (int i = ipfa_pkg::GROUP - 1; i >= 0; i--) begin
      if (reqs[i] && !found) begin
        one_hot[i] = 1'b1;
        found      = 1'b1;
      end
    end
    return one_hot;
  endfunction

  // Any upper group request shuts the whole lower group out
  function automatic logic [ipfa_pkg::PORTS-1:0] ipfa_pick(
    input logic [ipfa_pkg::PORTS-1:0] reqs
  );
    logic [ipfa_pkg::GROUP-1:0] upper;
    logic [ipfa_pkg::GROUP-1:0] lower;
    logic [ipfa_pkg::PORTS-1:0] one_hot;
    upper   = reqs[ipfa_pkg::PORTS-1:ipfa_pkg::GROUP];
    lower   = reqs[ipfa_pkg::GROUP-1:0];
    one_hot = {{ipfa_pkg::GROUP{1'b0}}, ipfa_group_pick(lower)}; // R16
    if (|upper) begin
      one_hot = {ipfa_group_pick(upper), {ipfa_pkg::GROUP{1'b0}}}; // R16
    end
    return one_hot;
  endfunction

  // Frame counts in units of four, so it is shifted before the add
  function automatic logic [ipfa_pkg::ADDR_W-1:0] ipfa_addr(
    input logic [ipfa_pkg::WORD_W-1:0] frame,
    input logic [ipfa_pkg::WORD_W-1:0] offs
  );
    logic [ipfa_pkg::ADDR_W-1:0] base;
    logic [ipfa_pkg::ADDR_W-1:0] offs_ext;
    base     = {frame, {ipfa_pkg::FRAME_SHIFT{1'b0}}};
    offs_ext = {{ipfa_pkg::FRAME_SHIFT{1'b0}}, offs};
    return base + offs_ext;
  endfunction

  // One-hot decode of a byte index; used for selection and last byte
  function automatic logic [ipfa_pkg::BLOCK_BYTES-1:0] ipfa_decode(
    input logic [ipfa_pkg::BSEL_W-1:0] idx
  );
    logic [ipfa_pkg::BLOCK_BYTES-1:0] one_hot;
    one_hot      = {ipfa_pkg::BLOCK_BYTES{1'b0}};
    one_hot[idx] = 1'b1;
    return one_hot;
  endfunction

  // Byte path
  logic [ipfa_pkg::ADDR_W-1:0]      fetch_addr;
  logic [ipfa_pkg::BSEL_W-1:0]      byte_sel;
  logic [ipfa_pkg::BLOCK_BYTES-1:0] byte_dec;
  ipfa_pkg::ipfa_block_t            byte_gated;
  ipfa_pkg::ipfa_block_t            read_bytes;
  logic [ipfa_pkg::BYTE_W-1:0]      cur_byte;
  logic [ipfa_pkg::WORD_W-1:0]      instr_word;
  logic                             last_byte_selected_n;

  // Fetch request and holding registers
  logic                             fetch_grant;
  logic                             load_en;
  logic                             load_now;
  logic                             fetch_source;
  logic                             byte_taken;
  logic                             block_wanted;
  logic                             request_done;
  logic [ipfa_pkg::WORD_W-1:0]      frame_upd;
  logic [ipfa_pkg::WORD_W-1:0]      offset_upd;
  ipfa_pkg::ipfa_block_t            hold_upd;
  logic                             req_upd;
  logic                             ready_upd;

  // Arbiter and registered outputs
  logic [ipfa_pkg::PORTS-1:0]       live_reqs;
  logic [ipfa_pkg::PORTS-1:0]       latch_upd;
  logic [ipfa_pkg::PORTS-1:0]       pick_upd;
  logic [ipfa_pkg::PORTS-1:0]       select_upd;
  logic                             pending_upd;
  logic                             stall_upd;
  logic [ipfa_pkg::WORD_W-1:0]      bus_upd;
  logic                             bus_drive;
  logic [ipfa_pkg::ADDR_W-1:0]      addr_upd;
  logic                             addr_drive;

  // The fetch port requests from its own flip-flop, not from a pin
  for (genvar p = 0; p < ipfa_pkg::PORTS; p++) begin : g_port
    if (p == ipfa_pkg::FETCH_PORT) begin : g_fetch
      assign live_reqs[p] = state_reg.fetch_req;
    end else begin : g_pin
      assign live_reqs[p] = !port_request_n[p]; // R13
    end
    // Gated selects rule out address bus clash while the gate is open
    if (ipfa_pkg::QUAL_MASK[p]) begin : g_gated
      assign select_upd[p] = pick_upd[p] && !arbitration_open; // R17
    end else begin : g_free
      assign select_upd[p] = pick_upd[p];
    end
  end

  // Holding bytes share one internal bus, gated by the decoder lines
  for (genvar b = 0; b < ipfa_pkg::BLOCK_BYTES; b++) begin : g_byte
    assign read_bytes[b] = mem_read_data[b*ipfa_pkg::BYTE_W
                                         +: ipfa_pkg::BYTE_W]; // R5
    assign byte_gated[b] = state_reg.hold[b]
                           & {ipfa_pkg::BYTE_W{byte_dec[b]}}; // R7
    assign hold_upd[b]   = load_now ? read_bytes[b]
                                    : state_reg.hold[b]; // R5 R6
  end

  // Address and byte index follow the registers, not this cycle's loads
  always_comb begin
    fetch_addr = ipfa_addr(state_reg.frame,
                           state_reg.code_offset_counter); // R3
    byte_sel   = fetch_addr[ipfa_pkg::BSEL_W-1:0]; // R7
    byte_dec   = ipfa_decode(byte_sel); // R7
    last_byte_selected_n = ~|(byte_dec
                              & ipfa_decode(ipfa_pkg::LAST_BYTE));
  end

  // Only the decoded byte is non-zero, so an OR acts as the multiplexer
  always_comb begin
    cur_byte = {ipfa_pkg::BYTE_W{1'b0}};
    for (int b = 0; b < ipfa_pkg::BLOCK_BYTES; b++) begin
      cur_byte = cur_byte | byte_gated[b]; // R7
    end
    instr_word = {{(ipfa_pkg::WORD_W-ipfa_pkg::BYTE_W){1'b0}}, cur_byte};
  end

  // Holding bytes load as grant-and-strobe falls, not when it rises
  always_comb begin
    fetch_grant = state_reg.port_select[ipfa_pkg::FETCH_PORT];
    load_en     = fetch_grant && memory_data_strobe;
    load_now    = state_reg.load_en_prev && !load_en; // R6
  end

  always_comb begin
    frame_upd = state_reg.frame;
    if (uop.dst_frame) begin
      frame_upd = bus_in; // R1
    end
  end

  // A fetch source is refused while the block is not ready
  always_comb begin
    fetch_source = uop.src_fetch || uop.special_byte_source; // R8
    byte_taken   = fetch_source && state_reg.block_ready; // R12
    offset_upd   = state_reg.code_offset_counter;
    if (uop.dst_offset) begin
      offset_upd = bus_in; // R1
    end else if (byte_taken) begin
      offset_upd = state_reg.code_offset_counter
                   + ipfa_pkg::OFFSET_STEP; // R9
    end
  end

  // A new cause for a block outranks a clear in the same cycle
  always_comb begin
    // Eighth byte through the special source does not ask for more
    block_wanted = (byte_taken && !last_byte_selected_n
                    && !uop.special_byte_source) // R10
                   || uop.dst_offset; // R11
    request_done = clear_request && fetch_grant; // R19
    req_upd      = state_reg.fetch_req;
    if (request_done) begin
      req_upd = 1'b0; // R19
    end
    if (block_wanted) begin
      req_upd = 1'b1; // R10 R11
    end
  end

  // Only a load after the request cleared carries the wanted block
  always_comb begin
    ready_upd = state_reg.block_ready;
    if (load_now && !state_reg.fetch_req) begin
      ready_upd = 1'b1; // R19
    end
    if (block_wanted) begin
      ready_upd = 1'b0;
    end
    stall_upd = !ready_upd; // R12
  end

  // Requests follow the pins while open and freeze while a cycle runs
  always_comb begin
    latch_upd = state_reg.req_latch;
    if (arbitration_open) begin
      latch_upd = live_reqs; // R15
    end
    // Pending reflects the latch, so a running cycle keeps it high
    pick_upd    = ipfa_pick(latch_upd); // R15 R16
    pending_upd = |latch_upd; // R13
  end

  // Register reads outrank the instruction byte on the BUS
  always_comb begin
    bus_drive = 1'b1;
    bus_upd   = ipfa_pkg::WORD_ZERO;
    if (uop.src_frame) begin
      bus_upd = state_reg.frame; // R2
    end else if (uop.src_offset) begin
      bus_upd = state_reg.code_offset_counter; // R2
    end else if (byte_taken) begin
      bus_upd = instr_word; // R8
    end else begin
      bus_drive = 1'b0;
    end
  end

  // The address follows loads made in this cycle, so it is never stale
  always_comb begin
    addr_drive = select_upd[ipfa_pkg::FETCH_PORT]; // R4
    addr_upd   = ipfa_pkg::ADDR_ZERO;
    if (addr_drive) begin
      addr_upd = ipfa_addr(frame_upd, offset_upd); // R3 R4
    end
  end

  // All registers move together; each field has one source above
  always_comb begin
    state_next                     = state_reg;
    state_next.frame               = frame_upd;
    state_next.code_offset_counter = offset_upd;
    state_next.hold                = hold_upd;
    state_next.fetch_req           = req_upd;
    state_next.block_ready         = ready_upd;
    state_next.load_en_prev        = load_en;
    state_next.req_latch           = latch_upd;
    state_next.port_select         = select_upd;
    state_next.request_pending     = pending_upd; // R13
    state_next.bus_out             = bus_upd;
    state_next.bus_out_en          = bus_drive;
    state_next.mem_addr            = addr_upd;
    state_next.mem_addr_en         = addr_drive;
    state_next.stall               = stall_upd; // R12
  end

  // Reset sets the fetch request so that a first block is fetched
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.frame               <= ipfa_pkg::FRAME_RST;
      state_reg.code_offset_counter <= ipfa_pkg::OFFSET_RST;
      state_reg.hold                <= ipfa_pkg::ipfa_block_t'(
                                         ipfa_pkg::READ_ZERO);
      state_reg.fetch_req           <= 1'b1;
      state_reg.block_ready         <= 1'b0;
      state_reg.load_en_prev        <= 1'b0;
      state_reg.req_latch           <= ipfa_pkg::PORTS_IDLE;
      state_reg.port_select         <= ipfa_pkg::PORTS_IDLE;
      state_reg.request_pending     <= 1'b0;
      state_reg.bus_out             <= ipfa_pkg::WORD_ZERO;
      state_reg.bus_out_en          <= 1'b0;
      state_reg.mem_addr            <= ipfa_pkg::ADDR_ZERO;
      state_reg.mem_addr_en         <= 1'b0;
      state_reg.stall               <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output comes straight from the state register
  assign bus_out         = state_reg.bus_out;
  assign bus_out_en      = state_reg.bus_out_en;
  assign mem_addr        = state_reg.mem_addr;
  assign mem_addr_en     = state_reg.mem_addr_en;
  assign port_select     = state_reg.port_select;
  assign request_pending = state_reg.request_pending;
  assign fetch_request_n = !state_reg.fetch_req;
  assign stall           = state_reg.stall;

endmodule // ipfa_fetch_arbiter

`default_nettype wire

/* File: ipfa_fetch_arbiter_tb.sv */
// Purpose: Self-checking bench for the fetch unit and arbiter
// Assumes: Memory cycle control model on the far side
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ipfa_fetch_arbiter_tb;
  typedef logic [38:0] ipfa_row_t;
  logic sys_clk, arst_n, strobe, clr, open, pend, fr_n, stall, out_en, a_en;
  ipfa_pkg::ipfa_uop_s uop;
  logic [15:0] bus_in, bus_out;
  logic [63:0] rd;
  logic [17:0] addr;
  logic [7:0]  req_n, sel;
  int          err_total = 0;
  int          num_checks = 0;
  int          pri[4] = '{6, 5, 2, 1};
  // Frame 0123 and offset 0005 give address 00491
  ipfa_row_t   rows[8] = '{{6'h20, 16'h0123, 16'h0000, 1'b0},
    {6'h10, 16'h0005, 16'h0000, 1'b0}, {6'h08, 16'h5a5a, 16'h0123, 1'b1},
    {6'h04, 16'h5a5a, 16'h0005, 1'b1}, {6'h02, 16'h5a5a, 16'h0091, 1'b1},
    {6'h02, 16'h5a5a, 16'h0092, 1'b1}, {6'h01, 16'h5a5a, 16'h0093, 1'b1},
    {6'h04, 16'h5a5a, 16'h0008, 1'b1}};
  ipfa_fetch_arbiter i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .uop(uop),
    .bus_in(bus_in), .mem_read_data(rd), .memory_data_strobe(strobe),
    .arbitration_open(open), .clear_request(clr), .port_request_n(req_n),
    .bus_out(bus_out), .bus_out_en(out_en), .mem_addr(addr),
    .mem_addr_en(a_en), .port_select(sel), .request_pending(pend),
    .fetch_request_n(fr_n), .stall(stall));
  ipfa_mem_ctrl i_mem (.sys_clk(sys_clk), .arst_n(arst_n),
    .request_pending(pend), .mem_addr_en(a_en), .mem_addr(addr),
    .arbitration_open(open), .memory_data_strobe(strobe),
    .clear_request(clr), .mem_read_data(rd));
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(input ipfa_pkg::ipfa_uop_s u, input logic [15:0] d);
    uop = u;
    bus_in = d;
    @(negedge sys_clk);
  endtask
  task automatic wait_ready();
    uop = '0;
    @(negedge sys_clk);
    for (int n = 0; n < 100 && stall !== 1'b0; n++) @(negedge sys_clk);
    `CHK(stall, 1'b0)
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    err_total++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    uop = '0;
    bus_in = 16'h0000;
    req_n = 8'hff;
    repeat (3) @(negedge sys_clk);
    `CHK({out_en, a_en, sel, fr_n, stall}, 12'h001)
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_ready();
      step(rows[i][38:33], rows[i][32:17]);
      `CHK({out_en, bus_out}, {rows[i][0], rows[i][16:1]})
    end
    // Last byte of a block, then a fetch while stalled
    step(6'h10, 16'h0003);
    for (int n = 0; n < 50 && a_en !== 1'b1; n++) @(negedge sys_clk);
    `CHK({a_en, addr}, {1'b1, 18'h0048f})
    wait_ready();
    step(6'h02, 16'h5a5a);
    `CHK({bus_out, fr_n, stall}, 18'h0023d)
    step(6'h02, 16'h5a5a);
    `CHK(out_en, 1'b0)
    wait_ready();
    step(6'h04, 16'h5a5a);
    `CHK(bus_out, 16'h0004)
    step(6'h10, 16'h0003);
    wait_ready();
    step(6'h01, 16'h5a5a);
    `CHK({bus_out, fr_n}, 17'h0011f)
    uop = '0;
    req_n = 8'h99;
    foreach (pri[j]) begin
      for (int n = 0; n < 50 && sel !== 8'h01 << pri[j]; n++)
        @(negedge sys_clk);
      `CHK({sel, a_en}, {8'h01 << pri[j], 1'b0})
      for (int n = 0; n < 50 && clr !== 1'b1; n++) @(negedge sys_clk);
      req_n[pri[j]] = 1'b1;
    end
    conclude();
  end
endmodule // ipfa_fetch_arbiter_tb
bind ipfa_fetch_arbiter ipfa_props i_props (.sys_clk(sys_clk),
  .arst_n(arst_n), .uop(uop), .arbitration_open(arbitration_open),
  .memory_data_strobe(memory_data_strobe), .clear_request(clear_request),
  .bus_out(bus_out), .bus_out_en(bus_out_en), .mem_addr_en(mem_addr_en),
  .port_select(port_select), .request_pending(request_pending),
  .fetch_request_n(fetch_request_n), .stall(stall));
`default_nettype wire

/* File: ipfa_mem_ctrl.sv */
// Purpose: Memory cycle control model facing the arbiter
// Assumes: Byte k of a block reads as address bits 7:3 with k
// Notes:   Read data inverts every cycle when not granted
`timescale 1ns/100ps
`default_nettype none
module ipfa_mem_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        request_pending,
  input  wire logic        mem_addr_en,
  input  wire logic [17:0] mem_addr,
  output logic             arbitration_open,
  output logic             memory_data_strobe,
  output logic             clear_request,
  output logic [63:0]      mem_read_data
);
  logic [2:0] st;
  // Two open idle states let the pending flag settle before a new cycle
  assign arbitration_open   = (st == 3'h0) || (st >= 3'h6);
  assign memory_data_strobe = (st == 3'h2) || (st == 3'h3);
  assign clear_request      = (st == 3'h3) || (st == 3'h4);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= 3'h0;
      mem_read_data <= 64'h0;
    end else begin
      st <= (st == 3'h0) ? {2'h0, request_pending} : st + 3'h1;
      for (int k = 0; k < 8; k++) begin
        mem_read_data[8*k +: 8] <= mem_addr_en ? {mem_addr[7:3], 3'(k)}
                                               : ~mem_read_data[8*k +: 8];
      end
    end
  end
endmodule // ipfa_mem_ctrl
`default_nettype wire

/* File: ipfa_pkg.sv */
// Purpose: Shared widths, constants and carrier types of the fetch unit
//          and memory port arbiter.
// Assumes: One microcycle clock; one microinstruction per clock.
// Notes:   The fetch unit occupies one arbiter port given by FETCH_PORT.
`default_nettype none

package ipfa_pkg;

  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BLOCK_BYTES = 8;
  localparam int unsigned BSEL_W      = 3;
  localparam int unsigned FRAME_SHIFT = 2;
  localparam int unsigned ADDR_W      = WORD_W + FRAME_SHIFT;
  localparam int unsigned READ_W      = BLOCK_BYTES * BYTE_W;
  localparam int unsigned PORTS       = 8;
  localparam int unsigned GROUP       = 4;

  // Port that belongs to the fetch unit; its request pin is ignored
  localparam int unsigned FETCH_PORT  = 0;
  // Selects gated by an open memory cycle (lower group)
  localparam logic [PORTS-1:0] QUAL_MASK = 8'h0f;
  localparam logic [BSEL_W-1:0] LAST_BYTE = 3'h7;
  localparam logic [WORD_W-1:0] OFFSET_STEP = 16'h0001;

  localparam logic [WORD_W-1:0] FRAME_RST  = 16'h0000;
  localparam logic [WORD_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [PORTS-1:0]  PORTS_IDLE = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [READ_W-1:0] READ_ZERO  = 64'h0000_0000_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 18'h00000;

  // Microinstruction fields that reference the fetch unit
  typedef struct packed {
    logic dst_frame;
    logic dst_offset;
    logic src_frame;
    logic src_offset;
    logic src_fetch;
    logic special_byte_source;
  } ipfa_uop_s;

  typedef logic [BLOCK_BYTES-1:0][BYTE_W-1:0] ipfa_block_t;

  typedef struct packed {
    logic [WORD_W-1:0] frame;
    logic [WORD_W-1:0] code_offset_counter;
    ipfa_block_t       hold;
    logic              fetch_req;
    logic              block_ready;
    logic              load_en_prev;
    logic [PORTS-1:0]  req_latch;
    logic [PORTS-1:0]  port_select;
    logic              request_pending;
    logic [WORD_W-1:0] bus_out;
    logic              bus_out_en;
    logic [ADDR_W-1:0] mem_addr;
    logic              mem_addr_en;
    logic              stall;
  } ipfa_state_s;

endpackage

`default_nettype wire

/* File: ipfa_props.sv */
// Purpose: Port assertions for the fetch unit and arbiter
// Assumes: Bound by name onto the top module
// Notes:   Single clock domain
`timescale 1ns/100ps
`default_nettype none
module ipfa_props (
  input wire logic                sys_clk,
  input wire logic                arst_n,
  input wire ipfa_pkg::ipfa_uop_s uop,
  input wire logic                arbitration_open,
  input wire logic                memory_data_strobe,
  input wire logic                clear_request,
  input wire logic [15:0]         bus_out,
  input wire logic                bus_out_en,
  input wire logic                mem_addr_en,
  input wire logic [7:0]          port_select,
  input wire logic                request_pending,
  input wire logic                fetch_request_n,
  input wire logic                stall
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic src_reg = uop.src_frame | uop.src_offset;
  sequence take_s; uop.src_fetch && !stall && !src_reg; endsequence
  sequence load_s;
    port_select[0] && $fell(memory_data_strobe) && fetch_request_n;
  endsequence
  addr_gate_a: assert property (mem_addr_en |-> port_select[0])
    else $error("address driven without fetch grant");
  one_grant_a: assert property ($onehot0(port_select))
    else $error("more than one port selected");
  qual_sel_a: assert property ($past(arbitration_open) |->
    port_select[3:0] == 4'h0) else $error("lower select while open");
  grant_a: assert property ($fell(arbitration_open) && request_pending
    |=> port_select != 8'h00) else $error("no select after gate closed");
  hold_a: assert property ($past(!arbitration_open) &&
    $past(!arbitration_open, 2) |-> $stable(port_select))
    else $error("select changed during cycle");
  pend_a: assert property (arbitration_open && !fetch_request_n
    |-> ##[1:2] request_pending) else $error("request not seen");
  req_load_a: assert property (uop.dst_offset |=> !fetch_request_n)
    else $error("offset load did not request block");
  req_clr_a: assert property (port_select[0] && clear_request &&
    !uop.dst_offset |=> fetch_request_n) else $error("request not cleared");
  byte_out_a: assert property (take_s |=> bus_out_en &&
    bus_out[15:8] == 8'h00) else $error("byte not driven");
  stall_a: assert property (stall && uop.src_fetch && !src_reg
    |=> !bus_out_en) else $error("fetch served while stalled");
  ready_a: assert property (load_s |-> ##[1:2] !stall)
    else $error("block not ready after load");
endmodule // ipfa_props
`default_nettype wire
